/* rtl/dram_ctl.sv */
// Purpose: host controller driving a 1K x 1 dynamic RAM over its pins
// Assumes: one strobe pin times every cycle; pins are synchronous to clk_sys
// Notes:   user requests take one cycle at a time; refresh has priority
// Summary of operation
// - Every cycle is timed only by the single enable strobe.
// - Refresh is 32 reads stepping the five lowest address bits.
// - Whole refresh sweep finishes within two milliseconds.
// - Strobe held inactive puts the device in low-power standby.
// - Strobe stays inactive at least 230 ns between cycles.
// - Read strobe stays active from 210 ns up to 500 ns.
// - Write pulse starts 210 ns to 500 ns after strobe goes active.
// - Write pulse stays active at least 50 ns.
`timescale 1ns/1ps
`include "dram_ctl_params.svh"
module dram_ctl
   import dram_ctl_pkg::*;
#(
   parameter int SLOT_CYC = `REFRESH_SLOT_CYC
) (
   input  wire logic                    clk_sys,
   input  wire logic                    srst,
   input  wire logic                    req_valid,
   input  wire op_type                  req_op,
   input  wire logic [`ADDR_WIDTH-1:0]  req_addr,
   input  wire logic                    req_wdata,
   output logic                         req_ready,
   output logic                         rsp_valid,
   output logic                         rsp_rdata,
   output logic                         strobe_en,
   output logic                         write_en,
   output logic [`ADDR_WIDTH-1:0]       word_address_lines,
   output logic                         data_in,
   input  wire logic                    data_out_n
);
   state_type                 st_q;
   logic [7:0]                tmr_q;      // Time within current cycle
   logic [7:0]                off_q;      // Time strobe has been off
   logic [7:0]                min_cyc_q;  // Cycle length of last cycle
   logic [7:0]                since_q;    // Time since last cycle start
   logic                      is_wr_q;
   logic                      is_rd_q;
   logic                      is_ref_q;
   logic                      ref_req;
   logic [`ROW_BITS-1:0]      ref_row;
   logic [7:0]                on_len_q;   // Strobe active cycles, for checks
   logic [7:0]                wp_len_q;   // Write pulse cycles, for checks

   // Start decision: refresh first, then user; gaps respected
   wire       usr_wr    = (req_op != OP_READ);
   wire       usr_rd    = (req_op != OP_WRITE);
   wire       gap_ok    = (off_q >= 8'(`STROBE_OFF_CYC)) && (since_q >= min_cyc_q);
   wire       wr_gap_ok = (since_q >= 8'(`WRITE_CYCLE_CYC));
   wire       can_start = (st_q == ST_IDLE) && gap_ok;
   wire       start_ref = can_start && ref_req;
   wire       start_usr = can_start && !ref_req && req_valid && (!usr_wr || wr_gap_ok);
   wire       ack_ref   = start_ref;
   wire       on_done   = (tmr_q == 8'(`STROBE_ON_CYC - 1));
   wire       wr_go     = (tmr_q == 8'(`WRITE_DELAY_CYC - 1));
   wire       wp_done   = (tmr_q == 8'(`WRITE_DELAY_CYC + `WRITE_PULSE_CYC - 1));
   wire       sample    = (tmr_q == 8'(`SAMPLE_CYC));
   wire [`ADDR_WIDTH-1:0] ref_addr = {{(`ADDR_WIDTH-`ROW_BITS){1'b0}}, ref_row};

   // Refresh pacing
   refresh_timer #(.SLOT_CYC(SLOT_CYC)) u_refresh (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ack     (ack_ref),
      .req     (ref_req),
      .row     (ref_row)
   );

   // Cycle sequencer; strobe is the only timing pin
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= ST_IDLE;
         tmr_q <= 8'h00;
      end else begin
         tmr_q <= (st_q == ST_IDLE) ? 8'h00 : tmr_q + 8'h01;
         unique case (st_q)
            ST_IDLE:     if (start_ref || start_usr) st_q <= ST_ON;
            ST_ON:       if (is_wr_q && wr_go) st_q <= ST_WR_PULSE;
                         else if (!is_wr_q && on_done) st_q <= ST_OFF;
            ST_WAIT_WR:  st_q <= ST_WR_PULSE;
            ST_WR_PULSE: if (wp_done) st_q <= ST_HOLD;
            ST_HOLD:     st_q <= ST_OFF;
            ST_OFF:      st_q <= ST_IDLE;
         endcase
      end
   end

   // Spacing counters for off time and cycle-to-cycle spacing
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         off_q <= 8'hFF;
         since_q <= 8'hFF;
         min_cyc_q <= 8'h00;
      end else begin
         if (strobe_en) off_q <= 8'h00;
         else if (off_q != 8'hFF) off_q <= off_q + 8'h01;
         if (start_ref || start_usr) begin
            since_q <= 8'h01;
            min_cyc_q <= (start_usr && usr_wr) ? 8'(`WRITE_CYCLE_CYC)
                                               : 8'(`READ_CYCLE_CYC);
         end else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
      end
   end

   // Pin drivers; strobe low outside cycles means standby
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         strobe_en <= 1'b0;
         write_en <= 1'b0;
         word_address_lines <= '0;
         data_in <= 1'b0;
         is_wr_q <= 1'b0;
         is_rd_q <= 1'b0;
         is_ref_q <= 1'b0;
      end else begin
         if (start_ref) begin
            strobe_en <= 1'b1;
            word_address_lines <= ref_addr;
            is_wr_q <= 1'b0;
            is_rd_q <= 1'b0;
            is_ref_q <= 1'b1;
         end else if (start_usr) begin
            strobe_en <= 1'b1;
            word_address_lines <= req_addr;
            data_in <= req_wdata;
            is_wr_q <= usr_wr;
            is_rd_q <= usr_rd;
            is_ref_q <= 1'b0;
         end else if (st_q == ST_HOLD || (st_q == ST_ON && !is_wr_q && on_done)) begin
            strobe_en <= 1'b0;
         end
         if (st_q == ST_ON && is_wr_q && wr_go) write_en <= 1'b1;
         else if (st_q == ST_WR_PULSE && wp_done) write_en <= 1'b0;
      end
   end

   // Read sampling and user handshake; output is complemented
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         rsp_valid <= (st_q == ST_ON || st_q == ST_WR_PULSE) && sample && is_rd_q;
         if ((st_q == ST_ON || st_q == ST_WR_PULSE) && sample && is_rd_q)
            rsp_rdata <= ~data_out_n;
         req_ready <= 1'b0;
         if (start_usr) req_ready <= 1'b1;
      end
   end

   // Check helpers: length of strobe and write pulse, saturating
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         on_len_q <= 8'h00;
         wp_len_q <= 8'h00;
      end else begin
         on_len_q <= !strobe_en ? 8'h00 : (on_len_q == 8'hFF) ? on_len_q : on_len_q + 8'h01;
         wp_len_q <= !write_en ? 8'h00 : (wp_len_q == 8'hFF) ? wp_len_q : wp_len_q + 8'h01;
      end
   end

   // Strobe width within bounds for reads
   read_strobe_a: assert property (@(posedge clk_sys) disable iff (srst)
      $fell(strobe_en) && !is_wr_q |->
         (on_len_q >= 8'(`STROBE_ON_CYC)) && (on_len_q <= 8'(`STROBE_ON_MAX_CYC)))
      else $error("read strobe width out of range");

   // Write pulse placement after strobe
   write_delay_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(write_en) |-> strobe_en && (on_len_q >= 8'(`WRITE_DELAY_CYC))
                          && (on_len_q <= 8'(`STROBE_ON_MAX_CYC)))
      else $error("write pulse placed out of range");

   // Write pulse width
   write_width_a: assert property (@(posedge clk_sys) disable iff (srst)
      $fell(write_en) |-> wp_len_q >= 8'(`WRITE_PULSE_CYC))
      else $error("write pulse too short");

   // Strobe off time between cycles
   strobe_off_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(strobe_en) |-> off_q >= 8'(`STROBE_OFF_CYC))
      else $error("strobe off too short");

   // Cycle spacing held
   cycle_space_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(strobe_en) |-> $past(since_q) >= 8'(`READ_CYCLE_CYC))
      else $error("cycles too close");

   // Spacing after a write or modify cycle held
   write_space_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(strobe_en) |-> $past(since_q) >= $past(min_cyc_q))
      else $error("write cycle spacing broken");

   // Write or modify cycle starts far enough after the previous start
   write_start_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(strobe_en) && is_wr_q |-> $past(since_q) >= 8'(`WRITE_CYCLE_CYC))
      else $error("write cycle started too soon");

   // Refresh address within row field
   refresh_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(strobe_en) && is_ref_q |-> word_address_lines[9:5] == 5'h00)
      else $error("refresh address out of rows");

   // Read data captured at the access time
   read_sample_a: assert property (@(posedge clk_sys) disable iff (srst)
      rsp_valid |-> strobe_en && ($past(on_len_q) >= 8'(`SAMPLE_CYC)))
      else $error("read sampled too early");

   // User ready only with the strobe of its own cycle
   ready_start_a: assert property (@(posedge clk_sys) disable iff (srst)
      req_ready |-> $rose(strobe_en) && !is_ref_q)
      else $error("ready without a user cycle");

   // No write pulse while in standby
   write_stby_a: assert property (@(posedge clk_sys) disable iff (srst)
      !strobe_en |-> !write_en)
      else $error("write pulse outside strobe");
endmodule : dram_ctl

/* rtl/dram_ctl_params.svh */
// Purpose: timing and geometry constants for the 1K x 1 dynamic RAM controller
// Assumes: 200 MHz system clock, 5 ns period
// Notes:   counts derived from times; minimums round up, maximums round down
`ifndef DRAM_CTL_PARAMS_SVH
`define DRAM_CTL_PARAMS_SVH

`define CLK_PERIOD_PS        5000
`define ADDR_WIDTH           10
`define ROW_BITS             5
`define ROW_COUNT            32
// Times in ns
`define STROBE_OFF_NS        230
`define STROBE_ON_MIN_NS     210
`define STROBE_ON_MAX_NS     500
`define READ_CYCLE_NS        480
`define WRITE_CYCLE_NS       580
`define STROBE_TO_WRITE_NS   210
`define WRITE_PULSE_NS       50
`define STROBE_OUT_DELAY_NS  185
// Refresh interval in us
`define REFRESH_INTERVAL_US  2000
// Cycle counts
`define STROBE_OFF_CYC       ((`STROBE_OFF_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STROBE_ON_CYC        ((`STROBE_ON_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STROBE_ON_MAX_CYC    ((`STROBE_ON_MAX_NS * 1000) / `CLK_PERIOD_PS)
`define READ_CYCLE_CYC       ((`READ_CYCLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_CYCLE_CYC      ((`WRITE_CYCLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_DELAY_CYC      ((`STROBE_TO_WRITE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_PULSE_CYC      ((`WRITE_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SAMPLE_CYC           ((`STROBE_OUT_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Sweep must finish inside the interval: one row slot = interval / rows, rounded down
`define REFRESH_SLOT_CYC     ((`REFRESH_INTERVAL_US * 1000000 / `CLK_PERIOD_PS) / `ROW_COUNT)

`endif

/* rtl/dram_ctl_pkg.sv */
// Purpose: types for the 1K x 1 dynamic RAM controller
// Assumes: nothing
// Notes:   constants live in dram_ctl_params.svh
package dram_ctl_pkg;
   typedef enum logic [1:0] {
      OP_READ,
      OP_WRITE,
      OP_MODIFY
   } op_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ON,
      ST_WAIT_WR,
      ST_WR_PULSE,
      ST_HOLD,
      ST_OFF
   } state_type;
endpackage : dram_ctl_pkg

/* rtl/refresh_timer.sv */
// Purpose: paces refresh reads so all 32 rows are visited within the interval
// Assumes: one refresh read per slot; controller acknowledges each read
// Notes:   request stays up until acknowledged; row steps on acknowledge
`timescale 1ns/1ps
`include "dram_ctl_params.svh"
module refresh_timer #(
   parameter int SLOT_CYC = `REFRESH_SLOT_CYC
) (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic                  ack,
   output logic                       req,
   output logic [`ROW_BITS-1:0]       row
);
   logic [23:0] cnt_q;
   wire         slot_done = (cnt_q == 24'(SLOT_CYC - 1));   // One row per slot

   // Slot counter and pending request; set wins over acknowledge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_q <= 24'h000000;
         req   <= 1'b0;
         row   <= '0;
      end else begin
         cnt_q <= slot_done ? 24'h000000 : cnt_q + 24'h000001;
         if (slot_done)
            req <= 1'b1;
         else if (ack)
            req <= 1'b0;
         if (ack)
            row <= row + 5'h01;   // Step through low address bits
      end
   end
endmodule : refresh_timer

/* tb/dram_ctl_tb.sv */
// Purpose: self-checking bench for the dynamic RAM controller
// Assumes: short refresh slot of 200 cycles
// Notes:   device timing breaches are reported by the model
`timescale 1ns/1ps
`include "dram_ctl_params.svh"
module dram_ctl_tb;
   import dram_ctl_pkg::*;
   localparam int SLOT = 200;
   logic                   clk_sys   = 1'b0;
   logic                   srst      = 1'b1;
   logic                   req_valid = 1'b0;
   op_type                 req_op    = OP_READ;
   logic [`ADDR_WIDTH-1:0] req_addr  = '0;
   logic                   req_wdata = 1'b0;
   logic [5:0]             lat       = 6'h01;
   logic                   req_ready, rsp_valid, rsp_rdata, strobe_en, write_en;
   logic                   data_in, data_out_n, rd;
   logic [`ADDR_WIDTH-1:0] word_address_lines;
   int                     n_viol, n_cyc = 0, n_mismatch = 0, n_tests = 0;

   dram_ctl #(.SLOT_CYC(SLOT)) i_dram_ctl (.clk_sys(clk_sys), .srst(srst),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .strobe_en(strobe_en), .write_en(write_en), .word_address_lines(word_address_lines),
      .data_in(data_in), .data_out_n(data_out_n));
   dram_model #(.REF_LIM(32 * SLOT + 1000)) i_dram_model (.clk_sys(clk_sys),
      .strobe_en(strobe_en), .write_en(write_en), .word_address_lines(word_address_lines),
      .data_in(data_in), .lat(lat), .data_out_n(data_out_n), .n_viol(n_viol));

   // Clock and watchdog
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      n_cyc++;
      if (n_cyc == 30000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
         n_mismatch++;
      end
   endtask : chk

   // One request held until ready is sampled; reads wait for the answer
   task automatic xfer(input op_type op, input logic [9:0] a, input logic w, output logic r);
      int i;
      req_op = op;
      req_addr = a;
      req_wdata = w;
      req_valid = 1'b1;
      for (i = 0; i < 2000 && req_ready !== 1'b1; i++) @(posedge clk_sys) #1;
      chk(32'h1, {31'h0, req_ready === 1'b1});
      @(posedge clk_sys) #1;
      req_valid = 1'b0;
      r = 1'bx;
      @(posedge clk_sys) #1;
      if (op != OP_WRITE) begin
         for (i = 0; i < 200 && rsp_valid !== 1'b1; i++) @(posedge clk_sys) #1;
         chk(32'h1, {31'h0, rsp_valid === 1'b1});
         r = rsp_rdata;
      end
   endtask : xfer

   // Spread of addresses written back to back, each read twice
   task automatic t_rw();
      logic [9:0] a [6] = '{10'h000, 10'h001, 10'h01F, 10'h020, 10'h2AA, 10'h3FF};
      foreach (a[i]) xfer(OP_WRITE, a[i], ^a[i], rd);
      foreach (a[i]) begin
         xfer(OP_READ, a[i], 1'b0, rd);
         chk(^a[i], rd);
         xfer(OP_READ, a[i], 1'b0, rd);
         chk(^a[i], rd);
      end
   endtask : t_rw

   // Modify returns the old bit and leaves the new one
   task automatic t_mod();
      xfer(OP_WRITE, 10'h155, 1'b0, rd);
      xfer(OP_MODIFY, 10'h155, 1'b1, rd);
      chk(32'h0, rd);
      xfer(OP_MODIFY, 10'h155, 1'b0, rd);
      chk(32'h1, rd);
      xfer(OP_READ, 10'h155, 1'b0, rd);
      chk(32'h0, rd);
   endtask : t_mod

   // Device answering late, just inside the output delay
   task automatic t_slow();
      lat = 6'h25;
      xfer(OP_READ, 10'h3FF, 1'b0, rd);
      chk(32'h0, rd);
      xfer(OP_READ, 10'h2AA, 1'b0, rd);
      chk(32'h1, rd);
      lat = 6'h01;
   endtask : t_slow

   // Idle sweep: refresh rows only, low address bits only
   task automatic t_refresh();
      int n_rise;
      logic en_p;
      n_rise = 0;
      en_p = 1'b1;
      repeat (32 * SLOT + 400) begin
         @(posedge clk_sys) #1;
         if (strobe_en === 1'b1 && en_p !== 1'b1) begin
            n_rise++;
            chk(32'h0, {27'h0, word_address_lines[9:5]});
            chk(32'h0, {31'h0, write_en});
         end
         en_p = strobe_en;
      end
      chk(32'h1, {31'h0, n_rise >= 32});
   endtask : t_refresh

   task automatic complete_run();
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      chk(32'h0, {30'h0, strobe_en, write_en});
      srst = 1'b0;
      t_rw();
      t_mod();
      t_slow();
      t_refresh();
      chk(32'h0, n_viol);
      complete_run();
   end
endmodule : dram_ctl_tb

/* tb/dram_model.sv */
// Purpose: behavioural 1K x 1 dynamic RAM on the far side of the controller
// Assumes: pins change just after clk_sys rising edges
// Notes:   breaches of controller timing are counted in n_viol
`timescale 1ns/1ps
`include "dram_ctl_params.svh"
module dram_model #(
   parameter int REF_LIM = 7400
) (
   input  wire logic                   clk_sys,
   input  wire logic                   strobe_en,
   input  wire logic                   write_en,
   input  wire logic [`ADDR_WIDTH-1:0] word_address_lines,
   input  wire logic                   data_in,
   input  wire logic [5:0]             lat,
   output logic                        data_out_n,
   output int                          n_viol
);
   logic [1023:0]          mem_q  = {512{2'b10}};
   logic [`ADDR_WIDTH-1:0] addr_q = '0;
   logic                   en_q   = 1'b0;
   logic                   wr_q   = 1'b0;
   logic                   tog_q  = 1'b0;
   int                     on_n   = 0;
   int                     off_n  = 1000;
   int                     gap_n  = 1000;
   int                     gap_p  = 1000;
   int                     wr_n   = 0;
   int                     age[32];
   initial n_viol = 0;
   initial foreach (age[i]) age[i] = 0;

   // Pin sampling, storage and timing checks
   always @(posedge clk_sys) begin
      tog_q <= ~tog_q;
      en_q  <= strobe_en;
      wr_q  <= write_en;
      off_n <= strobe_en ? 0 : off_n + 1;
      on_n  <= strobe_en ? on_n + 1 : 0;
      wr_n  <= write_en ? wr_n + 1 : 0;
      gap_n <= gap_n + 1;
      foreach (age[i]) age[i] <= age[i] + 1;
      if (strobe_en && !en_q) begin
         addr_q <= word_address_lines;
         age[word_address_lines[`ROW_BITS-1:0]] <= 0;
         gap_n <= 1;
         gap_p <= gap_n;
         if (off_n < `STROBE_OFF_CYC || gap_n < `READ_CYCLE_CYC)
            n_viol <= n_viol + 1;
      end
      if (!strobe_en && en_q && (on_n < `STROBE_ON_CYC || on_n > `STROBE_ON_MAX_CYC))
         n_viol <= n_viol + 1;
      if (write_en && !wr_q && (on_n < `WRITE_DELAY_CYC || on_n > `STROBE_ON_MAX_CYC
                                || gap_p < `WRITE_CYCLE_CYC))
         n_viol <= n_viol + 1;
      if (!write_en && wr_q && wr_n < `WRITE_PULSE_CYC) n_viol <= n_viol + 1;
      if (strobe_en && write_en) mem_q[addr_q] <= data_in;
      foreach (age[i]) if (age[i] > REF_LIM) n_viol <= n_viol + 1;
   end

   // Inverted bit after the access delay; a changing level in standby
   assign data_out_n = (strobe_en && on_n >= lat) ? ~mem_q[addr_q]
                                                  : tog_q;
endmodule : dram_model
